/* File: verification/sio_pin_model.sv */
// Outside circuit on the port pins
`timescale 1ns/1ps
module sio_pin_model (
    input  wire logic       clk,
    input  wire logic [5:0] pin_out,
    input  wire logic [5:0] pin_oe,
    input  wire logic [5:0] pin_pullup,
    input  wire logic [5:0] ext_en,
    input  wire logic [5:0] ext_val,
    output logic      [5:0] pin_in
);
    logic [5:0] drift = 6'h15;
    // Floating pins wander every cycle
    always @(posedge clk) drift <= ~drift;
    // Outside drives only pins the port leaves undriven
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                  | (~pin_oe & ~ext_en & (pin_pullup | drift));
endmodule

/* File: verification/sio_port_bench.sv */
// Testbench for the six pin port
`timescale 1ns/1ps
module sio_port_bench
    import sio_pkg::*;
;
    typedef struct packed {logic [7:0] opt; logic [5:0] dir, lat, ext;} sio_row_t;
    logic clk, rst, cyc_begin, cyc_end, rst_cause_valid, reg_rd, reg_wr, dir_load, opt_load;
    logic bit_set_instruction, bit_clear_instruction, master_reset_input_en;
    logic wake_request, wake_reset_flag;
    sio_rst_t   rst_cause;
    logic [4:0] reg_addr;
    logic [2:0] bit_index;
    logic [7:0] reg_wdata, w_data, reg_rdata, timer_and_pin_options, v;
    logic [5:0] alt_function, pin_in, pin_out, pin_oe, pin_pullup, ext_en, ext_val, e;
    int         miscompares, samples_checked;
    sio_row_t   rows [4] = '{'{8'hff, 6'h00, 6'h2a, 6'h15}, '{8'hdf, 6'h00, 6'h2a, 6'h15},
                             '{8'hdf, 6'h3f, 6'h3f, 6'h00}, '{8'h1f, 6'h2c, 6'h15, 6'h3f}};
    sio_port i_dut (.*);
    sio_pin_model i_pins (.*);
    task step; @(posedge clk); #1; endtask
    task chk(input string n, input logic [7:0] s, input logic [7:0] x);
        samples_checked++;
        if (s !== x) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, x, s);
        end
    endtask
    // One cycle end carrying a write or load, then an idle cycle
    task instr(input logic wr, input logic dl, input logic ol, input logic [7:0] d);
        {reg_wr, dir_load, opt_load, cyc_end} = {wr, dl, ol, 1'b1};
        reg_addr = SIO_ADDR_PORT; reg_wdata = d; w_data = d;
        step; {reg_wr, dir_load, opt_load, cyc_end} = 4'h0;
        step;
    endtask
    task rd(input logic [4:0] a);
        cyc_begin = 1; step; cyc_begin = 0; reg_rd = 1; reg_addr = a;
        step; reg_rd = 0; v = reg_rdata;
    endtask
    task reset_with(input sio_rst_t c);
        rst = 1; repeat (6) step; rst = 0; rst_cause = c; rst_cause_valid = 1;
        step; rst_cause_valid = 0; step;
    endtask
    task test_done;
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    initial begin
        #900000; miscompares++; test_done;
    end
    initial begin
        {cyc_begin, cyc_end, rst_cause_valid, reg_rd, reg_wr, dir_load, opt_load} = 0;
        {bit_set_instruction, bit_clear_instruction, master_reset_input_en, bit_index} = 0;
        {reg_addr, reg_wdata, w_data, alt_function, ext_val} = 0; ext_en = '1;
        reset_with(SIO_RST_POWER);
        chk("por", pin_out, 0);
        foreach (rows[i]) begin
            ext_val = rows[i].ext;
            instr(0, 0, 1, rows[i].opt); instr(0, 1, 0, {2'h0, rows[i].dir});
            instr(1, 0, 0, {2'h0, rows[i].lat});
            e = ~rows[i].dir & 6'h37 & (rows[i].opt[SIO_OPT_TCS] ? 6'h3b : 6'h3f);
            chk("oe", pin_oe, e);
            chk("out", pin_out, rows[i].lat);
            rd(SIO_ADDR_PORT); chk("read", v, {2'h0, (e & rows[i].lat) | (~e & rows[i].ext)});
        end
        $display("rows done");
        instr(0, 1, 0, 8'h38); ext_val = 6'h3f; cyc_begin = 1; step; cyc_begin = 0;
        bit_clear_instruction = 1; step; bit_clear_instruction = 0; instr(0, 0, 0, 0);
        chk("rmw", pin_out, 6'h3c);
        alt_function = 6'h04; rd(SIO_ADDR_PORT); chk("alt", v, 8'h38);
        alt_function = 0; rd(5'h1f); chk("unmapped", v, 0);
        instr(0, 1, 0, 8'h3f); rd(SIO_ADDR_PORT); chk("pull", pin_pullup, 6'h0b);
        ext_val = 6'h1f; #1 chk("nowake", wake_request, 0);
        ext_val = 6'h1e; #1 chk("wake", wake_request, 1);
        master_reset_input_en = 1; instr(0, 0, 1, 8'hff); chk("master_reset_input", pin_pullup, 6'h08);
        master_reset_input_en = 0; $display("port tests done");
        reset_with(SIO_RST_WAKE); chk("keep", pin_out, 6'h3c);
        chk("opt", timer_and_pin_options, 8'hff);
        rd(SIO_ADDR_STATUS); chk("status", v[7], 1);
        reset_with(SIO_RST_OTHER); chk("flag", wake_reset_flag, 0);
        chk("oe", pin_oe, 0);
        $display("reset tests done");
        test_done;
    end
endmodule

/* File: verification/sio_port_checker.sv */
// Boundary assertions for the six pin port
`timescale 1ns/1ps
module sio_port_checker
    import sio_pkg::*;
#(
    parameter int PINS = SIO_PINS
) (
    input wire logic            clk,
    input wire logic            rst,
    input wire logic [4:0]      reg_addr,
    input wire logic            reg_rd,
    input wire logic            cyc_end,
    input wire sio_rst_t        rst_cause,
    input wire logic            rst_cause_valid,
    input wire logic [PINS-1:0] alt_function,
    input wire logic            master_reset_input_en,
    input wire logic [7:0]      reg_rdata,
    input wire logic [PINS-1:0] pin_out,
    input wire logic [PINS-1:0] pin_oe,
    input wire logic [PINS-1:0] pin_pullup,
    input wire logic            wake_reset_flag,
    input wire logic [7:0]      timer_and_pin_options
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Port read request
    sequence s_port_read;
        reg_rd && reg_addr == SIO_ADDR_PORT;
    endsequence
    AST_UPPER_ZERO: assert property (s_port_read |=> reg_rdata[7:6] == SIO_UPPER_ZERO)
        else $error("upper port bits not zero");
    AST_ALT_ZERO: assert property (s_port_read |=> (reg_rdata[5:0] & $past(alt_function)) == '0)
        else $error("alternate pin read not zero");
    AST_RESET_STATE: assert property ($fell(rst) |-> pin_oe == '0 && timer_and_pin_options == SIO_OPT_RESET)
        else $error("state after reset wrong");
    AST_BIT3_IN: assert property (!pin_oe[SIO_BIT_THREE])
        else $error("bit three driven");
    AST_TCS_IN: assert property (timer_and_pin_options[SIO_OPT_TCS] |-> !pin_oe[SIO_BIT_TWO])
        else $error("bit two driven with timer pin source");
    AST_DIR_NO_PULL: assert property ((pin_pullup & pin_oe) == '0)
        else $error("pull-up on driven pin");
    AST_PULL_GROUP: assert property (!master_reset_input_en |-> (pin_pullup & ~(SIO_GROUP_MASK & {PINS{!timer_and_pin_options[SIO_OPT_PULLUP_N]}})) == '0)
        else $error("pull-up outside enabled group");
    AST_MASTER_RESET_INPUT_PULL: assert property (master_reset_input_en |-> pin_pullup[SIO_BIT_THREE])
        else $error("reset input pull-up off");
    AST_LATCH_HOLD: assert property (!$past(rst) && !$past(cyc_end) && !$past(rst_cause_valid) |-> $stable(pin_out))
        else $error("latch changed without write");
    AST_WAKE_FLAG: assert property (rst_cause_valid |=> wake_reset_flag == ($past(rst_cause) == SIO_RST_WAKE))
        else $error("wake flag wrong for cause");
endmodule
bind sio_port sio_port_checker #(.PINS(PINS)) i_chk (.*);

/* File: verilog/sio_pin_cell.sv */
// One port pin: driver enable, pull-up and change detect
`timescale 1ns/1ps
module sio_pin_cell (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic dir_in,
    input  wire logic force_input,
    input  wire logic out_latch,
    input  wire logic pin_level,
    input  wire logic pullup_allow,
    input  wire logic wake_allow,
    input  wire logic sample_en,
    output logic      pin_out,
    output logic      pin_oe,
    output logic      pullup_on,
    output logic      change
);
    typedef struct packed {
        logic ref_level;
    } sio_cell_t;
    sio_cell_t state;
    sio_cell_t next_state;
    logic      drive;

    // Driver on only with direction zero and no override
    assign drive     = !dir_in && !force_input;
    assign pin_out   = out_latch;
    assign pin_oe    = drive;
    // Pull-up and wake switched off for driven pins
    assign pullup_on = pullup_allow && dir_in;
    assign change    = wake_allow && dir_in && (pin_level != state.ref_level);

    // Reference level for change detection
    always_comb begin
        next_state = state;
        if (sample_en) begin
            next_state.ref_level = pin_level;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= '1; // Idle level of a pulled-up pin, no false change
        end else begin
            state <= next_state;
        end
    end
endmodule

/* File: verilog/sio_pkg.sv */
// Constants and types for the six pin I/O port
package sio_pkg;
    localparam int          SIO_PINS           = 6;
    localparam logic [4:0]  SIO_ADDR_STATUS    = 5'h03;
    localparam logic [4:0]  SIO_ADDR_PORT      = 5'h06;
    localparam logic [5:0]  SIO_DIR_RESET      = 6'h3f;
    localparam logic [7:0]  SIO_OPT_RESET      = 8'hff;
    localparam int          SIO_OPT_WAKE_N     = 7;
    localparam int          SIO_OPT_PULLUP_N   = 6;
    localparam int          SIO_OPT_TCS        = 5;
    localparam int          SIO_STAT_WAKE      = 7;
    localparam int          SIO_BIT_TWO        = 2;
    localparam int          SIO_BIT_THREE      = 3;
    localparam logic [5:0]  SIO_GROUP_MASK     = 6'h0b;
    localparam logic [1:0]  SIO_UPPER_ZERO     = 2'h0;
    // Reset causes
    typedef enum logic [2:0] {
        SIO_RST_POWER = 3'b001,
        SIO_RST_OTHER = 3'b010,
        SIO_RST_WAKE  = 3'b100
    } sio_rst_t;
    // Phases of one instruction cycle (begin sample, end update)
    typedef enum logic [1:0] {
        SIO_PH_BEGIN = 2'b01,
        SIO_PH_END   = 2'b10
    } sio_phase_t;
endpackage

/* File: verilog/sio_port.sv */
// Six bit general purpose I/O port with direction and option registers
//
// Contract
// - Port reads return pin levels regardless of direction, not latches.
// - Every reset sets all direction bits to one, pins become inputs.
// - Port register is eight bits; bits seven and six read zero.
// - Port bit three is input only; its driver never enables.
// - Pins assigned to alternate functions read as zero.
// - Pull-ups and wake on change serve bits zero, one, three as group.
// - Bit three as reset input: pull-up always on, no wake.
// - Direction loads only by direction-load instruction; not readable.
// - Direction one is high impedance; zero drives the output latch.
// - Port bit two direction also overridable by option register.
// - Inputs not latched; output latches hold until rewritten.
// - All bits except three individually set as input or output.
// - Bit set and clear rewrite all latches from pin levels.
// - Writes update pins at cycle end; reads sample at cycle start.
// - Wake flag set on wake reset, cleared on other resets.
// - Option register resets to all ones on every reset.
// - Option bit seven wake enable, bit six pull-up enable, active low.
// - Direction zero disables wake and pull-up for that pin, except bit three as reset input.
// - Timer clock-source select one forces bit two to input.
`timescale 1ns/1ps
module sio_port
    import sio_pkg::*;
#(
    parameter int PINS = SIO_PINS
) (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                cyc_begin,
    input  wire logic                cyc_end,
    input  wire sio_rst_t            rst_cause,
    input  wire logic                rst_cause_valid,
    input  wire logic [4:0]          reg_addr,
    input  wire logic                reg_rd,
    input  wire logic                reg_wr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                bit_set_instruction,
    input  wire logic                bit_clear_instruction,
    input  wire logic [2:0]          bit_index,
    input  wire logic                dir_load,
    input  wire logic                opt_load,
    input  wire logic [7:0]          w_data,
    input  wire logic [PINS-1:0]     alt_function,
    input  wire logic                master_reset_input_en,
    input  wire logic [PINS-1:0]     pin_in,
    output logic [7:0]               reg_rdata,
    output logic [PINS-1:0]          pin_out,
    output logic [PINS-1:0]          pin_oe,
    output logic [PINS-1:0]          pin_pullup,
    output logic                     wake_request,
    output logic                     wake_reset_flag,
    output logic [7:0]               timer_and_pin_options
);
    typedef struct packed {
        logic [PINS-1:0] pin_direction_control;
        logic [7:0]      options;
        logic [PINS-1:0] latch;
        logic [PINS-1:0] sampled;
        logic            wake_flag;
        logic            rmw_pending;
        logic [PINS-1:0] rmw_value;
        logic [7:0]      rdata;
    } sio_state_t;

    sio_state_t      state;
    sio_state_t      next_state;
    sio_state_t      ctrl_q;
    sio_state_t      hold_q;
    logic [PINS-1:0] dir_eff;
    logic [PINS-1:0] force_in;
    logic [PINS-1:0] group_pullup;
    logic [PINS-1:0] group_wake;
    logic [PINS-1:0] change;
    logic [PINS-1:0] port_view;
    logic            pullups_n;
    logic            wakes_n;
    logic            tcs;

    assign pullups_n = state.options[SIO_OPT_PULLUP_N];
    assign wakes_n   = state.options[SIO_OPT_WAKE_N];
    assign tcs       = state.options[SIO_OPT_TCS];

    // Per pin overrides and group enables
    always_comb begin
        dir_eff      = state.pin_direction_control;
        force_in     = '0;
        group_pullup = '0;
        group_wake   = '0;
        force_in[SIO_BIT_THREE] = 1'b1;
        force_in[SIO_BIT_TWO]   = tcs;
        for (int i = 0; i < PINS; i++) begin
            if (SIO_GROUP_MASK[i]) begin
                group_pullup[i] = !pullups_n;
                group_wake[i]   = !wakes_n;
            end
        end
        if (master_reset_input_en) begin
            group_pullup[SIO_BIT_THREE] = 1'b1;
            group_wake[SIO_BIT_THREE]   = 1'b0;
            dir_eff[SIO_BIT_THREE]      = 1'b1;
        end
    end

    // One cell per pin
    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : gen_pin
            sio_pin_cell u_cell (
                .clk          (clk),
                .rst          (rst),
                .dir_in       (dir_eff[g]),
                .force_input  (force_in[g]),
                .out_latch    (state.latch[g]),
                .pin_level    (pin_in[g]),
                .pullup_allow (group_pullup[g]),
                .wake_allow   (group_wake[g]),
                .sample_en    (cyc_begin),
                .pin_out      (pin_out[g]),
                .pin_oe       (pin_oe[g]),
                .pullup_on    (pin_pullup[g]),
                .change       (change[g])
            );
        end
    endgenerate

    // Pin levels as seen by a port read, alternate pins masked
    assign port_view = state.sampled & ~alt_function;

    assign wake_request          = |change;
    assign wake_reset_flag       = state.wake_flag;
    assign timer_and_pin_options = state.options;
    assign reg_rdata             = state.rdata;

    // Register behaviour per instruction cycle
    always_comb begin
        next_state = state;
        // Sample pins at cycle start; inputs are not latched
        if (cyc_begin) begin
            next_state.sampled = pin_in;
        end
        if (reg_rd) begin
            case (reg_addr)
                SIO_ADDR_PORT: begin
                    next_state.rdata = {SIO_UPPER_ZERO, port_view};
                end
                SIO_ADDR_STATUS: begin
                    next_state.rdata = '0;
                    next_state.rdata[SIO_STAT_WAKE] = state.wake_flag;
                end
                default: begin
                    next_state.rdata = '0;
                end
            endcase
        end
        // Bit set/clear: modify one bit of the pin view, rewrite all latches
        if ((bit_set_instruction || bit_clear_instruction)
                && reg_addr == SIO_ADDR_PORT && !state.rmw_pending) begin
            next_state.rmw_pending = 1'b1;
            next_state.rmw_value   = port_view;
            if (bit_index < 3'(PINS)) begin
                next_state.rmw_value[bit_index] = bit_set_instruction;
            end
        end
        // Writes land at cycle end; latches hold otherwise
        if (cyc_end) begin
            if (state.rmw_pending) begin
                next_state.latch       = state.rmw_value;
                next_state.rmw_pending = 1'b0;
            end else if (reg_wr && reg_addr == SIO_ADDR_PORT) begin
                next_state.latch = reg_wdata[PINS-1:0];
            end
            if (reg_wr && reg_addr == SIO_ADDR_STATUS) begin
                next_state.wake_flag = reg_wdata[SIO_STAT_WAKE];
            end
            if (dir_load) begin
                next_state.pin_direction_control = w_data[PINS-1:0];
            end
            if (opt_load) begin
                next_state.options = w_data;
            end
        end
        // Reset cause recorded on release
        if (rst_cause_valid) begin
            next_state.wake_flag = (rst_cause == SIO_RST_WAKE);
            if (rst_cause == SIO_RST_POWER) begin
                next_state.latch = '0;
            end
        end
    end

    // One state view: controls from the reset copy, data from the held copy
    always_comb begin
        state           = ctrl_q;
        state.latch     = hold_q.latch;
        state.sampled   = hold_q.sampled;
        state.wake_flag = hold_q.wake_flag;
        state.rmw_value = hold_q.rmw_value;
    end

    // Controls forced by reset; each copy has a single driver
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q                       <= '0;
            ctrl_q.pin_direction_control <= SIO_DIR_RESET;
            ctrl_q.options               <= SIO_OPT_RESET;
        end else begin
            ctrl_q <= next_state;
        end
    end

    // Data held across resets, latches survive every reset but power-on, which clears them
    always_ff @(posedge clk) begin
        hold_q <= next_state;
    end
endmodule
